/* File: rtl/sug_defs.vh */
// Purpose: Shared constants of the unlock host controller
// Assumes: 200 MHz system clock
// Notes:   Times are kept in their own unit; cycle counts derive from them
`ifndef SUG_DEFS_VH
`define SUG_DEFS_VH

// ----------------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------------
`define SUG_CLK_PS        5000

// ----------------------------------------------------------------------------
// Pin timing, in ns as printed (power-up time in ms)
// ----------------------------------------------------------------------------
`define SUG_T_RST_NS      200
`define SUG_T_ACCESS_NS   200
`define SUG_T_RECOV_NS    50
`define SUG_T_SELMAX_NS   1500
`define SUG_T_PWRUP_MS    10

// ----------------------------------------------------------------------------
// Derived cycle counts (least times rounded up except power-up, which divides down; longest down)
// ----------------------------------------------------------------------------
`define SUG_RST_CYC    ((`SUG_T_RST_NS * 1000 + `SUG_CLK_PS - 1) / `SUG_CLK_PS)
`define SUG_STB_CYC    ((`SUG_T_ACCESS_NS * 1000 + `SUG_CLK_PS - 1) / `SUG_CLK_PS)
`define SUG_RCV_CYC    ((`SUG_T_RECOV_NS * 1000 + `SUG_CLK_PS - 1) / `SUG_CLK_PS)
`define SUG_SELMAX_CYC ((`SUG_T_SELMAX_NS * 1000) / `SUG_CLK_PS)
// Worked in ns over ns per cycle so the product stays inside 32 bits
`define SUG_PWRUP_CYC  ((`SUG_T_PWRUP_MS * 1000000) / (`SUG_CLK_PS / 1000))

// ----------------------------------------------------------------------------
// Sequence sizes
// ----------------------------------------------------------------------------
`define SUG_CODE_BITS     64
`define SUG_LAST_BIT      7'h3F
`define SUG_BYTE_LAST     3'h7

// ----------------------------------------------------------------------------
// Controller states
// ----------------------------------------------------------------------------
`define SUG_S_PWRUP       3'h0
`define SUG_S_IDLE        3'h1
`define SUG_S_RESET       3'h2
`define SUG_S_CODE        3'h3
`define SUG_S_IDENT       3'h4
`define SUG_S_OPEN        3'h5
`define SUG_S_MEM         3'h6

`endif

/* File: rtl/sug_fifo.v */
// Purpose: Small synchronous FIFO with registered read data
// Assumes: One clock, asynchronous active-low reset
// Notes:   Output stage is a register so read data leave a flip-flop
module sug_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_sys,
  input  wire             rst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output reg              out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            do_push;
  wire            do_pop;

  // ----------------------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------------------
  // Full is honest: the output register does not count as a slot
  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign do_push  = in_valid && in_ready;
  assign do_pop   = (count_reg != {(AW+1){1'b0}}) && (out_ready || !out_valid);

  // Storage array, no reset needed
  always @(posedge clk_sys) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers, fill level and output stage
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
      out_valid  <= 1'b0;
      out_data   <= {WIDTH{1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        out_data   <= mem_reg[rd_ptr_reg];
        out_valid  <= 1'b1;
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end else if (out_ready) begin
        out_valid  <= 1'b0;
      end
      if (do_push && !do_pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

/* File: rtl/sug_host.v */
// Purpose: Host controller that unlocks a secured RAM gate and then runs RAM cycles
// Assumes: 200 MHz clk_sys; the gate is a strobe-driven device with one data pin
// Notes:   Identification bits are packed into bytes and buffered in a FIFO
//
// Operation
// - Start each attempt with a 200 ns reset
// - Write 64 code bits, one per cycle
// - Do 64 identification reads without intervening write
// - Keep each select pulse under 1.5 us
`include "sug_defs.vh"

module sug_host #(
  parameter PWRUP_CYC = `SUG_PWRUP_CYC,
  parameter CNT_W     = 21,
  parameter FIFO_W    = 8,
  parameter FIFO_D    = 8
) (
  input  wire              clk_sys,
  input  wire              rst_n,
  input  wire              unlock_start,
  input  wire [63:0]       unlock_code,
  output reg               busy,
  output reg               unlocked,
  output wire              id_valid,
  output wire [FIFO_W-1:0] id_data,
  input  wire              id_ready,
  input  wire              acc_valid,
  input  wire              acc_write,
  input  wire [1:0]        acc_addr,
  input  wire              acc_wbit,
  output reg               acc_ready,
  output reg               rd_valid,
  output reg               rd_bit,
  output reg               dev_rst_n,
  output reg               dev_ce_n,
  output reg               dev_rd_n,
  output reg               dev_we_n,
  output reg  [1:0]        dev_addr,
  output reg               dev_dq_out,
  output reg               dev_dq_oe_n,
  input  wire              dev_dq_in
);

  localparam integer     PWRUP_LAST_I = PWRUP_CYC - 1;
  localparam integer     RST_LAST_I   = `SUG_RST_CYC - 1;
  localparam integer     STB_LAST_I   = `SUG_STB_CYC - 1;
  localparam integer     CYC_LAST_I   = `SUG_STB_CYC + `SUG_RCV_CYC - 1;
  // Cut to the counter width on purpose; every count fits in CNT_W bits
  localparam [CNT_W-1:0] PWRUP_LAST   = PWRUP_LAST_I[CNT_W-1:0];
  localparam [CNT_W-1:0] RST_LAST     = RST_LAST_I[CNT_W-1:0];
  localparam [CNT_W-1:0] STB_LAST     = STB_LAST_I[CNT_W-1:0];
  localparam [CNT_W-1:0] CYC_LAST     = CYC_LAST_I[CNT_W-1:0];

  reg [2:0]        state_reg;
  reg [CNT_W-1:0]  cnt_reg;
  reg              act_reg;
  reg [6:0]        bit_reg;
  reg [63:0]       code_reg;
  reg [7:0]        id_byte_reg;
  reg              push_reg;
  reg [7:0]        push_data_reg;
  reg              samp_reg;
  reg              mem_wr_reg;
  reg              mem_bit_reg;
  reg              dq_s1_reg;
  reg              dq_s2_reg;
  wire             fifo_in_ready;
  reg              go;
  reg              cur_write;
  reg              cur_bit;
  wire             cyc_done;
  wire [7:0]       id_byte_next;

  // ----------------------------------------------------------------------------
  // Identification byte buffer
  // ----------------------------------------------------------------------------
  sug_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D),
    .AW    ($clog2(FIFO_D))
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (push_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data_reg),
    .out_valid (id_valid),
    .out_ready (id_ready),
    .out_data  (id_data)
  );

  // Data pin is asynchronous to clk_sys
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dq_s1_reg <= 1'b0;
      dq_s2_reg <= 1'b0;
    end else begin
      dq_s1_reg <= dev_dq_in;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  // ----------------------------------------------------------------------------
  // Pin cycle selection
  // ----------------------------------------------------------------------------
  assign cyc_done     = act_reg && (cnt_reg == CYC_LAST);
  assign id_byte_next = {samp_reg, id_byte_reg[7:1]};

  // Stall identification reads at a byte boundary until the FIFO has room;
  // a pause between reads is harmless as long as no write slips in
  always @* begin
    go        = 1'b0;
    cur_write = 1'b0;
    cur_bit   = 1'b0;
    case (state_reg)
      `SUG_S_CODE: begin
        go        = 1'b1;
        cur_write = 1'b1;
        cur_bit   = code_reg[0];
      end
      `SUG_S_IDENT: begin
        go = (bit_reg[2:0] != 3'h0) || (!push_reg && fifo_in_ready);
      end
      `SUG_S_MEM: begin
        go        = 1'b1;
        cur_write = mem_wr_reg;
        cur_bit   = mem_bit_reg;
      end
      default: begin
        go = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // Sequencer and pin drivers
  // ----------------------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= `SUG_S_PWRUP;
      cnt_reg       <= {CNT_W{1'b0}};
      act_reg       <= 1'b0;
      bit_reg       <= 7'h00;
      code_reg      <= 64'h0000000000000000;
      id_byte_reg   <= 8'h00;
      push_reg      <= 1'b0;
      push_data_reg <= 8'h00;
      samp_reg      <= 1'b0;
      mem_wr_reg    <= 1'b0;
      mem_bit_reg   <= 1'b0;
      busy          <= 1'b1;
      unlocked      <= 1'b0;
      acc_ready     <= 1'b0;
      rd_valid      <= 1'b0;
      rd_bit        <= 1'b0;
      dev_rst_n     <= 1'b1;
      dev_ce_n      <= 1'b1;
      dev_rd_n      <= 1'b1;
      dev_we_n      <= 1'b1;
      dev_addr      <= 2'h0;
      dev_dq_out    <= 1'b0;
      dev_dq_oe_n   <= 1'b1;
    end else begin
      push_reg <= 1'b0;
      rd_valid <= 1'b0;

      // One pin cycle: strobe phase then recovery, well under the select limit
      if (act_reg) begin
        cnt_reg <= cnt_reg + 1'b1;
        if (cnt_reg == STB_LAST) begin
          dev_ce_n <= 1'b1;
          dev_we_n <= 1'b1;
          dev_rd_n <= 1'b1;
          samp_reg <= dq_s2_reg;
        end
        if (cyc_done) begin
          act_reg     <= 1'b0;
          dev_dq_oe_n <= 1'b1;
        end
      end else if (go) begin
        act_reg  <= 1'b1;
        cnt_reg  <= {CNT_W{1'b0}};
        dev_ce_n <= 1'b0;
        if (cur_write) begin
          dev_we_n    <= 1'b0;
          dev_dq_out  <= cur_bit;
          dev_dq_oe_n <= 1'b0;
        end else begin
          dev_rd_n    <= 1'b0;
        end
      end

      case (state_reg)
        // No pin cycle until the gate has recovered from power-up
        `SUG_S_PWRUP: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == PWRUP_LAST) begin
            cnt_reg   <= {CNT_W{1'b0}};
            busy      <= 1'b0;
            state_reg <= `SUG_S_IDLE;
          end
        end
        `SUG_S_IDLE, `SUG_S_OPEN: begin
          if (acc_valid && acc_ready) begin
            acc_ready   <= 1'b0;
            busy        <= 1'b1;
            mem_wr_reg  <= acc_write;
            mem_bit_reg <= acc_wbit;
            dev_addr    <= acc_addr;
            state_reg   <= `SUG_S_MEM;
          end else if (unlock_start) begin
            // Every attempt, including a retry, opens with a reset pulse
            acc_ready <= 1'b0;
            busy      <= 1'b1;
            unlocked  <= 1'b0;
            code_reg  <= unlock_code;
            cnt_reg   <= {CNT_W{1'b0}};
            dev_rst_n <= 1'b0;
            state_reg <= `SUG_S_RESET;
          end else begin
            acc_ready <= (state_reg == `SUG_S_OPEN);
          end
        end
        `SUG_S_RESET: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == RST_LAST) begin
            cnt_reg   <= {CNT_W{1'b0}};
            dev_rst_n <= 1'b1;
            bit_reg   <= 7'h00;
            state_reg <= `SUG_S_CODE;
          end
        end
        // Writes only; a read here would abort the attempt
        `SUG_S_CODE: begin
          if (cyc_done) begin
            code_reg <= {1'b0, code_reg[63:1]};
            bit_reg  <= bit_reg + 1'b1;
            if (bit_reg == `SUG_LAST_BIT) begin
              bit_reg   <= 7'h00;
              state_reg <= `SUG_S_IDENT;
            end
          end
        end
        `SUG_S_IDENT: begin
          if (cyc_done) begin
            id_byte_reg <= id_byte_next;
            bit_reg     <= bit_reg + 1'b1;
            if (bit_reg[2:0] == `SUG_BYTE_LAST) begin
              push_reg      <= 1'b1;
              push_data_reg <= id_byte_next;
            end
            if (bit_reg == `SUG_LAST_BIT) begin
              unlocked  <= 1'b1;
              busy      <= 1'b0;
              state_reg <= `SUG_S_OPEN;
            end
          end
        end
        `SUG_S_MEM: begin
          if (cyc_done) begin
            rd_valid  <= !mem_wr_reg;
            rd_bit    <= samp_reg;
            busy      <= 1'b0;
            state_reg <= unlocked ? `SUG_S_OPEN : `SUG_S_IDLE;
          end
        end
        default: begin
          state_reg <= `SUG_S_IDLE;
        end
      endcase
    end
  end

endmodule

/* File: test/sug_gate_model.sv */
// Purpose: Behavioural security gate with four RAM selects
// Assumes: Strobe-edge driven, supply level set by the bench
// Notes:   Released data line shows inverse of last bit
module sug_gate_model #(
  parameter logic [63:0] ACC_CODE = 64'h0123456789ABCDEF, // arbitrary value
  parameter logic [63:0] ID_BITS  = 64'h5A3C96F00F69C3A5  // arbitrary value
) (
  input  logic       rst_pin_n,
  input  logic       ce_n,
  input  logic       rd_n,
  input  logic       we_n,
  input  logic [1:0] addr,
  input  logic       host_dq,
  input  logic       host_oe_n,
  input  logic       supply_ok,
  output logic       dq_line,
  output logic [3:0] ram_select_out_n
);
  logic [63:0] code_reg = 64'h0;
  logic [1:0]  phase = 2'h0; // 0 dead, 1 code, 2 id, 3 open
  int          cnt = 0;
  logic [3:0]  mem = 4'h0;
  logic        drv = 1'b0;
  logic        bit_q = 1'b0;
  logic        hold_sel = 1'b0;
  logic [3:0]  sel_held = 4'hF;
  // Supply loss relocks; a cycle in flight keeps its select until ce_n rises
  always @(negedge supply_ok) begin
    sel_held = ram_select_out_n;
    hold_sel = !ce_n;
    phase = 2'h0;
  end
  always @(posedge ce_n) hold_sel = 1'b0;
  // Reset pin restarts the sequence and relocks
  always @(negedge rst_pin_n) begin
    phase = 2'h1;
    cnt = 0;
  end
  // Write ends: capture code, never into RAM while locked
  always @(posedge we_n) begin
    if (phase == 2'h1) begin
      code_reg[cnt] = host_dq;
      cnt++;
      if (cnt == 64) begin
        phase = (code_reg === ACC_CODE) ? 2'h2 : 2'h0;
        cnt = 0;
      end
    end else if (phase == 2'h2) phase = 2'h0;
    else if (phase == 2'h3) mem[addr] = host_dq;
  end
  // Read start: early read aborts; code pattern never driven
  always @(negedge rd_n) begin
    if (phase == 2'h1) phase = 2'h0;
    drv = phase[1];
    if (phase[1]) bit_q = (phase == 2'h2) ? ID_BITS[cnt] : mem[addr];
  end
  // Read end: 64th id read opens the bank
  always @(posedge rd_n) begin
    drv = 1'b0;
    if (phase == 2'h2) begin
      cnt++;
      if (cnt == 64) phase = 2'h3;
    end
  end
  assign dq_line = !host_oe_n ? host_dq : (drv ? bit_q : ~bit_q);
  assign ram_select_out_n = !supply_ok ? (hold_sel ? sel_held : 4'hF) :
    (phase == 2'h3 && !ce_n) ? 4'hF ^ (4'h1 << addr) : 4'hF;
endmodule

/* File: test/sug_host_checker.sv */
// Purpose: Assertions on the unlock host's pins
// Assumes: One clock domain, async active-low reset
// Notes:   Counters restart with each gate reset pulse, except pc, which runs once after rst_n
module sug_host_checker #(
  parameter PWRUP_CYC = 20
) (
  input logic       clk_sys,
  input logic       rst_n,
  input logic       unlocked,
  input logic       rd_valid,
  input logic       id_valid,
  input logic       id_ready,
  input logic       dev_rst_n,
  input logic       dev_ce_n,
  input logic       dev_rd_n,
  input logic       dev_we_n,
  input logic [1:0] dev_addr,
  input logic       dev_dq_out,
  input logic       dev_dq_oe_n
);
  int rl, cl, wc, rc, pc;
  // Event counters; each attempt starts from zero, except the power-up count pc
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rl <= 0;
      cl <= 0;
      wc <= 0;
      rc <= 0;
      pc <= 0;
    end else begin
      rl <= dev_rst_n ? 0 : rl + 1;
      cl <= dev_ce_n ? 0 : cl + 1;
      wc <= !dev_rst_n ? 0 : wc + $fell(dev_we_n);
      rc <= !dev_rst_n ? 0 : rc + $fell(dev_rd_n);
      pc <= (pc < PWRUP_CYC) ? pc + 1 : pc;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_rst_len; $rose(dev_rst_n) |-> rl >= 40; endproperty
  a_rst_len: assert property (p_rst_len) else $error("gate reset too short");
  property p_wr_drv; $fell(dev_we_n) |-> !dev_ce_n && !dev_dq_oe_n; endproperty
  a_wr_drv: assert property (p_wr_drv) else $error("write without data");
  property p_wr_hold; !dev_we_n && $past(!dev_we_n) |-> $stable(dev_dq_out); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("data moved in write");
  property p_no_rd; $fell(dev_rd_n) && !unlocked |-> wc >= 64; endproperty
  a_no_rd: assert property (p_no_rd) else $error("read before code done");
  property p_id_run; $fell(dev_we_n) |-> wc < 64 || unlocked; endproperty
  a_id_run: assert property (p_id_run) else $error("write in id run");
  property p_unlock; $rose(unlocked) |-> rc == 64; endproperty
  a_unlock: assert property (p_unlock) else $error("unlock count wrong");
  property p_addr; !dev_ce_n && $past(!dev_ce_n) |-> $stable(dev_addr); endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_pwrup; $fell(dev_rst_n) || $fell(dev_ce_n) |-> pc == PWRUP_CYC; endproperty
  a_pwrup: assert property (p_pwrup) else $error("cycle before recovery");
  property p_ce_len; $rose(dev_ce_n) |-> cl >= 34 && cl <= 300; endproperty
  a_ce_len: assert property (p_ce_len) else $error("select pulse width");
  c_unl: cover property ($rose(unlocked));
  c_rd: cover property (rd_valid);
  c_id: cover property (id_valid && id_ready);
endmodule

/* File: test/tb_sug_host.sv */
// Purpose: Self-checking bench of the unlock host
// Assumes: Gate model on the far side
// Notes:   Short power-up wait keeps the run brief
module tb_sug_host;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] GOOD = 64'h0123456789ABCDEF;
  localparam logic [63:0] IDV  = 64'h5A3C96F00F69C3A5;
  localparam int          PWR  = 20;
  logic clk_sys = 0, rst_n = 0, unlock_start = 0, id_ready = 0, acc_valid = 0;
  logic acc_write = 0, acc_wbit = 0, busy, unlocked, id_valid, acc_ready, rd_valid, rd_bit;
  logic [63:0] unlock_code = 0;
  logic [1:0] acc_addr = 0, dev_addr;
  logic [7:0] id_data;
  logic dev_rst_n, dev_ce_n, dev_rd_n, dev_we_n, dev_dq_out, dev_dq_oe_n, dev_dq_in;
  logic [3:0] sel, sel_seen = 4'hF;
  logic supply_ok = 1'b1;
  int err_total = 0;
  int check_count = 0;
  always #2.5 clk_sys = ~clk_sys;
  // Remember any select that went low
  always @(posedge clk_sys) sel_seen = sel_seen & sel;
  sug_host #(.PWRUP_CYC(PWR)) i_dut(.clk_sys, .rst_n, .unlock_start, .unlock_code, .busy,
    .unlocked, .id_valid, .id_data, .id_ready, .acc_valid, .acc_write, .acc_addr, .acc_wbit,
    .acc_ready, .rd_valid, .rd_bit, .dev_rst_n, .dev_ce_n, .dev_rd_n, .dev_we_n, .dev_addr,
    .dev_dq_out, .dev_dq_oe_n, .dev_dq_in);
  sug_gate_model #(.ACC_CODE(GOOD), .ID_BITS(IDV)) i_gate(.rst_pin_n(dev_rst_n),
    .ce_n(dev_ce_n), .rd_n(dev_rd_n), .we_n(dev_we_n), .addr(dev_addr), .host_dq(dev_dq_out),
    .host_oe_n(dev_dq_oe_n), .supply_ok(supply_ok), .dq_line(dev_dq_in),
    .ram_select_out_n(sel));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wait_idle;
    int n = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    chk(busy, 1'b0);
  endtask
  // Reset for 8 cycles, then time the power-up wait
  task automatic t_reset;
    int n = 0;
    rst_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    chk(unlocked, 1'b0);
    chk(busy, 1'b1);
    rst_n = 1'b1;
    while (busy === 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    chk(n, PWR);
    chk(acc_ready, 1'b0);
  endtask
  // Unlock with consumer stalled, so all 8 bytes queue (FIFO stops one short of full), then drain
  task automatic t_unlock(input logic [63:0] code, input logic ok);
    logic [63:0] got = 0;
    int k = 0;
    id_ready = 1'b0;
    unlock_code = code;
    unlock_start = 1'b1;
    @(negedge clk_sys);
    unlock_start = 1'b0;
    sel_seen = 4'hF;
    @(negedge clk_sys);
    wait_idle;
    chk(unlocked, 1'b1);
    chk(sel_seen, 4'hF);
    id_ready = 1'b1;
    repeat (40) begin
      if (id_valid === 1'b1 && k < 8) begin
        got[k*8 +: 8] = id_data;
        k++;
      end
      @(negedge clk_sys);
    end
    chk(k, 8);
    if (ok) chk(got, IDV);
  endtask
  task automatic acc_op(input logic w, input logic [1:0] a, input logic b);
    int n = 0;
    logic rv = 1'b0;
    acc_valid = 1'b1;
    acc_write = w;
    acc_addr = a;
    acc_wbit = b;
    // Ready is judged where settled; the next rising edge takes the request
    while (acc_ready !== 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    acc_valid = 1'b0;
    n = 0;
    while (acc_ready !== 1'b1 && n < 400) begin
      @(negedge clk_sys);
      rv = rv | (rd_valid === 1'b1);
      n++;
    end
    chk(acc_ready, 1'b1);
    chk(rv, !w);
  endtask
  // Write then read one RAM bit, watching which select fell
  task automatic t_ram(input logic [1:0] a, input logic b);
    sel_seen = 4'hF;
    acc_op(1'b1, a, b);
    acc_op(1'b0, a, 1'b0);
    chk(rd_bit, b);
    chk(sel_seen, 4'hF ^ (4'h1 << a));
  endtask
  // Supply dip: selects stay shut, and stay shut once it returns
  task automatic t_supply;
    supply_ok = 1'b0;
    sel_seen = 4'hF;
    acc_op(1'b1, 2'h0, 1'b1);
    chk(sel_seen, 4'hF);
    supply_ok = 1'b1;
    acc_op(1'b1, 2'h0, 1'b1);
    chk(sel_seen, 4'hF);
  endtask
  // Last code bit wrong: bank must stay shut
  task automatic t_bad;
    t_unlock(GOOD ^ 64'h8000000000000000, 1'b0);
    sel_seen = 4'hF;
    acc_op(1'b1, 2'h1, 1'b1);
    chk(sel_seen, 4'hF);
  endtask
  initial begin
    t_reset;
    t_unlock(GOOD, 1'b1);
    for (int a = 0; a < 4; a++) t_ram(a[1:0], ~a[0]);
    t_supply;
    t_bad;
    t_reset;
    t_unlock(GOOD, 1'b1);
    t_ram(2'h2, 1'b1);
    report_and_stop;
  end
  // Three unlocks need about 100 us; allow four times that
  initial begin
    #400000;
    err_total++;
    report_and_stop;
  end
endmodule
bind sug_host sug_host_checker #(.PWRUP_CYC(PWRUP_CYC)) i_chk(.clk_sys, .rst_n, .unlocked,
  .rd_valid, .id_valid, .id_ready, .dev_rst_n, .dev_ce_n, .dev_rd_n, .dev_we_n, .dev_addr,
  .dev_dq_out, .dev_dq_oe_n);
